// >>> logic/metrology_front_end.sv
`timescale 1ns/1ns
//
// Contract
// RQ1 - raw samples readable at words 0 to 0xa
// RQ2 - slot selector value picks input handle 0-10
// RQ3 - pairs 2-3, 4-5, 6-7 direct or remote
// RQ4 - differential 2-3 uses handle 2, location 2
// RQ5 - remote pair writes lower location, no handle
// RQ6 - voltage inputs single-ended, never remote, unconfigured
// RQ7 - voltages use handles and locations 8, 9, 10
// RQ8 - status word at engine address 0x80
// RQ9 - busy interrupt once per sample frame
// RQ10 - status shows the last completed pass
// RQ11 - status bits 31 to 4 read zero
// RQ12 - status bit 3 is line frequency square
// RQ13 - sag flag sets after count low samples
// RQ14 - sag flag clears only above threshold
// RQ15 - configuration word at 0x20, default 0x0030da20
// RQ16 - external temperature bit selects compensation owner
// RQ17 - external pulse uses processor words 0x44, 0x48
// RQ18 - internal pulse uses energy sums 0x84, 0x88
// RQ19 - word bytes: msb at four times address
// RQ20 - external temperature is configuration bit 22
// RQ21 - sag counter restarts on any high sample
// RQ22 - differential pair 0-1 uses handle 0 only
//
module metrology_front_end
	import metrology_pkg::*;
#(
	parameter int CPU_ADDR_W = 12
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tickPin,
	input wire logic [3:0] multiplexerDivider,
	input wire logic pair01DifferentialEnable,
	input wire logic pair23DifferentialEnable,
	input wire logic pair45DifferentialEnable,
	input wire logic pair67DifferentialEnable,
	input wire logic pair23RemoteEnable,
	input wire logic pair45RemoteEnable,
	input wire logic pair67RemoteEnable,
	input wire logic adcSampleValid,
	input wire logic [3:0] frameSlotInputSelect,
	input wire logic [WORD_W-1:0] adcSample,
	input wire logic remoteSampleValid,
	input wire logic [1:0] remotePair,
	input wire logic [WORD_W-1:0] remoteSample,
	input wire logic [WORD_W-1:0] realEnergySum,
	input wire logic [WORD_W-1:0] reactiveEnergySum,
	input wire logic [WORD_W-1:0] engineGainA,
	input wire logic [WORD_W-1:0] engineGainB,
	input wire logic [WORD_W-1:0] engineGainC,
	input wire logic [CPU_ADDR_W-1:0] cpuAddr,
	input wire logic cpuWrEn,
	input wire logic [7:0] cpuWrData,
	input wire logic cpuRdEn,
	output logic [7:0] cpuRdData,
	output logic cpuRdValid,
	output logic computeBusyPulse,
	output logic [STATUS_W-1:0] engineStatus,
	output logic tempCompByProcessor,
	output logic [WORD_W-1:0] activeGainA,
	output logic [WORD_W-1:0] activeGainB,
	output logic [WORD_W-1:0] activeGainC,
	output logic [WORD_W-1:0] pulseRateReal,
	output logic [WORD_W-1:0] pulseRateReactive
);

	// ***********************************
	// state
	// ***********************************
	typedef struct packed {
		logic tickSync1;
		logic tickSync2;
		logic tickPrev;
		logic [4:0] frameCount;
		pass_stage_t stage;
		logic [LOC_COUNT-1:0][WORD_W-1:0] raw;
		logic [WORD_W-1:0] cfgWord;
		logic [WORD_W-1:0] sagThreshold;
		logic [2:0][WORD_W-1:0] gainWord;
		logic [WORD_W-1:0] pulseReal;
		logic [WORD_W-1:0] pulseReact;
		logic [WORD_W-1:0] realSum;
		logic [WORD_W-1:0] reactSum;
		logic f0;
		logic [STATUS_W-1:0] status;
		logic [7:0] rdData;
		logic rdValid;
		logic busyPulse;
		logic tempByCpu;
		logic [2:0][WORD_W-1:0] activeGain;
		logic [WORD_W-1:0] rateReal;
		logic [WORD_W-1:0] rateReact;
	} front_state_t;

	localparam front_state_t STATE_RESET = '{
		cfgWord: CONFIG_RESET,
		sagThreshold: SAG_THRESHOLD_RESET,
		gainWord: {3{GAIN_RESET}},
		pulseReal: PULSE_RATE_RESET,
		pulseReact: PULSE_RATE_RESET,
		stage: PASS_IDLE,
		default: '0
	};

	front_state_t state_reg;
	front_state_t state_next;

	// ***********************************
	// helpers
	// ***********************************
	// frame is conversions times cycles per conversion plus one settling cycle
	function automatic logic [4:0] frameLength(input logic [3:0] div);
		logic [4:0] prod;
		prod = 5'({div, 1'b0});
		frameLength = prod + SETTLE_CYCLES - 5'h01 + (CYCLES_PER_CONV - 5'h02);
	endfunction

	// returns {valid, location}; handles of remote pairs find no location
	function automatic logic [4:0] handleLocation(input logic [3:0] handle,
			input logic [3:0] diffVec, input logic [3:0] rmtVec);
		logic [1:0] pair;
		pair = handle[2:1];
		handleLocation = 5'h00;
		if (handle <= HANDLE_LAST_CURRENT) begin
			if (!rmtVec[pair] && !(diffVec[pair] && handle[0])) begin
				handleLocation = {1'b1, handle}; // see RQ4 // see RQ22
			end
		end else if (handle <= HANDLE_VC) begin
			handleLocation = {1'b1, handle}; // see RQ7 // see RQ6
		end
	endfunction

	function automatic logic [7:0] pickByte(input logic [WORD_W-1:0] word,
			input logic [1:0] lane);
		logic [4:0] shift;
		shift = 5'({~lane, 3'b000});
		pickByte = 8'(word >> shift); // see RQ19
	endfunction

	function automatic logic [WORD_W-1:0] putByte(input logic [WORD_W-1:0] word,
			input logic [1:0] lane, input logic [7:0] data);
		logic [4:0] shift;
		shift = 5'({~lane, 3'b000});
		putByte = (word & ~(32'h000000ff << shift)) | (WORD_W'(data) << shift);
	endfunction

	// ***********************************
	// sag detection, one tracker per phase
	// ***********************************
	logic [2:0] sagFlags;
	logic evaluate;

	assign evaluate = state_reg.stage == PASS_EVALUATE;

	genvar ph;
	generate
		for (ph = 0; ph < 3; ph++) begin : gPhase
			sag_phase_tracker #(
				.CNT_W(CFG_SAG_SAMPLE_COUNT_W)
			) uTracker (
				.sys_clk(sys_clk),
				.rst(rst),
				.passStrobe(evaluate),
				.voltageSample(state_reg.raw[int'(HANDLE_VA) + ph]),
				.sagThreshold(state_reg.sagThreshold),
				.sagSampleCount(state_reg.cfgWord[CFG_SAG_SAMPLE_COUNT_LSB +: CFG_SAG_SAMPLE_COUNT_W]),
				.sagFlag(sagFlags[ph])
			);
		end
	endgenerate

	// ***********************************
	// next state
	// ***********************************
	logic [3:0] diffVec;
	logic [3:0] rmtVec;
	logic [4:0] adcTarget;
	logic [3:0] remoteLoc;
	logic remoteHit;
	logic tickEdge;
	logic [WORD_ADDR_W-1:0] wordIdx;
	logic [1:0] lane;
	logic [WORD_W-1:0] rdWord;
	logic [1:0] freqSel;
	logic [WORD_W-1:0] f0Source;
	logic extTemp;
	logic extPulse;

	assign diffVec = {pair67DifferentialEnable, pair45DifferentialEnable,
		pair23DifferentialEnable, pair01DifferentialEnable};
	// pair 0-1 has no remote option
	assign rmtVec = {pair67RemoteEnable, pair45RemoteEnable, pair23RemoteEnable, 1'b0}; // see RQ3

	always_comb begin
		state_next = state_reg;
		wordIdx = cpuAddr[2 +: WORD_ADDR_W];
		lane = cpuAddr[1:0];
		extTemp = state_reg.cfgWord[CFG_EXTERNAL_TEMPERATURE_CONTROL_BIT]; // see RQ20
		extPulse = state_reg.cfgWord[CFG_EXTERNAL_PULSE_CONTROL_BIT];
		freqSel = state_reg.cfgWord[CFG_FREQSEL_LSB +: 2];

		// pin synchroniser, then edge of the 32768 Hz reference
		state_next.tickSync1 = tickPin;
		state_next.tickSync2 = state_reg.tickSync1;
		state_next.tickPrev = state_reg.tickSync2;
		tickEdge = state_reg.tickSync2 && !state_reg.tickPrev;

		// ***********************************
		// raw sample routing
		// ***********************************
		adcTarget = 5'h00;
		if (adcSampleValid) begin
			adcTarget = handleLocation(frameSlotInputSelect, diffVec, rmtVec); // see RQ2
		end
		remoteLoc = 4'({remotePair + 2'h1, 1'b0});
		remoteHit = remoteSampleValid && remotePair != 2'h3 && rmtVec[remotePair + 2'h1];
		for (int i = 0; i < LOC_COUNT; i++) begin
			if (remoteHit && remoteLoc == 4'(i)) begin
				state_next.raw[i] = remoteSample; // see RQ5
			end else if (adcTarget[4] && adcTarget[3:0] == 4'(i)) begin
				state_next.raw[i] = adcSample;
			end
		end

		// ***********************************
		// sample frame and engine pass
		// ***********************************
		state_next.busyPulse = 1'b0;
		if (tickEdge) begin
			if (state_reg.frameCount >= frameLength(multiplexerDivider)) begin
				state_next.frameCount = '0;
			end else begin
				state_next.frameCount = state_reg.frameCount + 5'h01;
			end
		end
		case (state_reg.stage)
			PASS_IDLE: begin
				if (tickEdge && state_reg.frameCount >= frameLength(multiplexerDivider)) begin
					state_next.stage = PASS_EVALUATE; // see RQ9
				end
			end
			PASS_EVALUATE: begin
				case (freqSel)
					FREQSEL_A: f0Source = state_reg.raw[HANDLE_VA];
					FREQSEL_B: f0Source = state_reg.raw[HANDLE_VB];
					default: f0Source = state_reg.raw[HANDLE_VC];
				endcase
				// sign of the chosen voltage follows the fundamental
				state_next.f0 = !f0Source[WORD_W-1]; // see RQ12
				state_next.stage = PASS_PUBLISH;
			end
			PASS_PUBLISH: begin
				// trackers settled last edge, so status and interrupt agree
				state_next.status = {state_reg.f0, sagFlags}; // see RQ10
				state_next.realSum = realEnergySum;
				state_next.reactSum = reactiveEnergySum;
				state_next.busyPulse = 1'b1; // see RQ9
				state_next.stage = PASS_IDLE;
			end
			default: begin
				state_next.stage = PASS_IDLE;
			end
		endcase
		f0Source = '0;
		if (state_reg.stage == PASS_EVALUATE) begin
			case (freqSel)
				FREQSEL_A: f0Source = state_reg.raw[HANDLE_VA];
				FREQSEL_B: f0Source = state_reg.raw[HANDLE_VB];
				default: f0Source = state_reg.raw[HANDLE_VC];
			endcase
			state_next.f0 = !f0Source[WORD_W-1];
		end

		// ***********************************
		// processor byte access
		// ***********************************
		rdWord = '0;
		if (wordIdx <= ADDR_RAW_LAST) begin
			rdWord = state_reg.raw[wordIdx[3:0]]; // see RQ1
		end else if (wordIdx == ADDR_CONFIG) begin
			rdWord = state_reg.cfgWord;
		end else if (wordIdx == ADDR_SAG_THRESHOLD) begin
			rdWord = state_reg.sagThreshold;
		end else if (wordIdx >= ADDR_GAIN_FIRST && wordIdx <= ADDR_GAIN_LAST) begin
			rdWord = state_reg.gainWord[wordIdx[1:0]];
		end else if (wordIdx == ADDR_PULSE_REAL) begin
			rdWord = state_reg.pulseReal;
		end else if (wordIdx == ADDR_PULSE_REACT) begin
			rdWord = state_reg.pulseReact;
		end else if (wordIdx == ADDR_STATUS) begin
			rdWord = {{(WORD_W-STATUS_W){1'b0}}, state_reg.status}; // see RQ8 // see RQ11
		end else if (wordIdx == ADDR_REAL_SUM) begin
			rdWord = state_reg.realSum;
		end else if (wordIdx == ADDR_REACT_SUM) begin
			rdWord = state_reg.reactSum;
		end
		state_next.rdValid = cpuRdEn;
		if (cpuRdEn) begin
			state_next.rdData = pickByte(rdWord, lane);
		end
		// raw, status and sums are engine outputs; writes to them are dropped
		if (cpuWrEn) begin
			if (wordIdx == ADDR_CONFIG) begin
				state_next.cfgWord = putByte(state_reg.cfgWord, lane, cpuWrData); // see RQ15
			end else if (wordIdx == ADDR_SAG_THRESHOLD) begin
				state_next.sagThreshold = putByte(state_reg.sagThreshold, lane, cpuWrData);
			end else if (wordIdx >= ADDR_GAIN_FIRST && wordIdx <= ADDR_GAIN_LAST) begin
				state_next.gainWord[wordIdx[1:0]] =
					putByte(state_reg.gainWord[wordIdx[1:0]], lane, cpuWrData);
			end else if (wordIdx == ADDR_PULSE_REAL) begin
				state_next.pulseReal = putByte(state_reg.pulseReal, lane, cpuWrData);
			end else if (wordIdx == ADDR_PULSE_REACT) begin
				state_next.pulseReact = putByte(state_reg.pulseReact, lane, cpuWrData);
			end
		end

		// ***********************************
		// compensation and pulse source
		// ***********************************
		state_next.tempByCpu = extTemp; // see RQ16
		state_next.activeGain[0] = extTemp ? state_reg.gainWord[0] : engineGainA;
		state_next.activeGain[1] = extTemp ? state_reg.gainWord[1] : engineGainB;
		state_next.activeGain[2] = extTemp ? state_reg.gainWord[2] : engineGainC;
		if (extPulse) begin
			state_next.rateReal = state_reg.pulseReal; // see RQ17
			state_next.rateReact = state_reg.pulseReact;
		end else begin
			state_next.rateReal = state_reg.realSum; // see RQ18
			state_next.rateReact = state_reg.reactSum;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ***********************************
	// outputs, all from flip-flops
	// ***********************************
	assign cpuRdData = state_reg.rdData;
	assign cpuRdValid = state_reg.rdValid;
	assign computeBusyPulse = state_reg.busyPulse;
	assign engineStatus = state_reg.status;
	assign tempCompByProcessor = state_reg.tempByCpu;
	assign activeGainA = state_reg.activeGain[0];
	assign activeGainB = state_reg.activeGain[1];
	assign activeGainC = state_reg.activeGain[2];
	assign pulseRateReal = state_reg.rateReal;
	assign pulseRateReactive = state_reg.rateReact;

endmodule // metrology_front_end

// >>> logic/metrology_pkg.sv
package metrology_pkg;

	// ***********************************
	// word layout and engine addresses
	// ***********************************
	localparam int WORD_W = 32;
	localparam int WORD_ADDR_W = 10;
	localparam int LOC_COUNT = 11;
	localparam logic [WORD_ADDR_W-1:0] ADDR_RAW_LAST = 10'h00a;
	localparam logic [WORD_ADDR_W-1:0] ADDR_CONFIG = 10'h020;
	localparam logic [WORD_ADDR_W-1:0] ADDR_SAG_THRESHOLD = 10'h024;
	localparam logic [WORD_ADDR_W-1:0] ADDR_GAIN_FIRST = 10'h040;
	localparam logic [WORD_ADDR_W-1:0] ADDR_GAIN_LAST = 10'h042;
	localparam logic [WORD_ADDR_W-1:0] ADDR_PULSE_REAL = 10'h044;
	localparam logic [WORD_ADDR_W-1:0] ADDR_PULSE_REACT = 10'h048;
	localparam logic [WORD_ADDR_W-1:0] ADDR_STATUS = 10'h080;
	localparam logic [WORD_ADDR_W-1:0] ADDR_REAL_SUM = 10'h084;
	localparam logic [WORD_ADDR_W-1:0] ADDR_REACT_SUM = 10'h088;

	// ***********************************
	// reset values
	// ***********************************
	localparam logic [WORD_W-1:0] CONFIG_RESET = 32'h0030da20;
	localparam logic [WORD_W-1:0] SAG_THRESHOLD_RESET = 32'h00000000;
	localparam logic [WORD_W-1:0] GAIN_RESET = 32'h00000000;
	localparam logic [WORD_W-1:0] PULSE_RATE_RESET = 32'h00000000;

	// ***********************************
	// configuration and status fields
	// ***********************************
	localparam int CFG_EXTERNAL_TEMPERATURE_CONTROL_BIT = 22;
	localparam int CFG_EXTERNAL_PULSE_CONTROL_BIT = 4;
	localparam int CFG_SAG_SAMPLE_COUNT_LSB = 8;
	localparam int CFG_SAG_SAMPLE_COUNT_W = 12;
	localparam int CFG_FREQSEL_LSB = 6;
	localparam int STATUS_W = 4;
	localparam int STATUS_F0_BIT = 3;

	// ***********************************
	// handles and frame timing
	// ***********************************
	localparam logic [3:0] HANDLE_LAST_CURRENT = 4'h7;
	localparam logic [3:0] HANDLE_VA = 4'h8;
	localparam logic [3:0] HANDLE_VB = 4'h9;
	localparam logic [3:0] HANDLE_VC = 4'ha;
	localparam logic [4:0] CYCLES_PER_CONV = 5'h02;
	localparam logic [4:0] SETTLE_CYCLES = 5'h01;
	localparam logic [1:0] FREQSEL_A = 2'h0;
	localparam logic [1:0] FREQSEL_B = 2'h1;

	typedef enum logic [1:0] {PASS_IDLE, PASS_EVALUATE, PASS_PUBLISH} pass_stage_t;

endpackage

// >>> logic/sag_phase_tracker.sv
`timescale 1ns/1ns
module sag_phase_tracker
	import metrology_pkg::*;
#(
	parameter int CNT_W = CFG_SAG_SAMPLE_COUNT_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic passStrobe,
	input wire logic [WORD_W-1:0] voltageSample,
	input wire logic [WORD_W-1:0] sagThreshold,
	input wire logic [CNT_W-1:0] sagSampleCount,
	output logic sagFlag
);

	typedef struct packed {
		logic [CNT_W-1:0] lowCount;
		logic flag;
	} tracker_state_t;

	tracker_state_t state_reg;
	tracker_state_t state_next;
	logic [CNT_W-1:0] bumped;

	always_comb begin
		state_next = state_reg;
		bumped = state_reg.lowCount;
		if (state_reg.lowCount != {CNT_W{1'b1}}) begin
			bumped = state_reg.lowCount + CNT_W'(1);
		end
		if (passStrobe) begin
			if ($signed(voltageSample) < $signed(sagThreshold)) begin
				state_next.lowCount = bumped;
				if (bumped >= sagSampleCount) begin
					state_next.flag = 1'b1; // see RQ13
				end
			end else begin
				state_next.lowCount = '0; // see RQ21
				// equal to the threshold is not a rise, so the flag holds
				if ($signed(voltageSample) > $signed(sagThreshold)) begin
					state_next.flag = 1'b0; // see RQ14
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sagFlag = state_reg.flag;

endmodule // sag_phase_tracker

// >>> bench/metrology_front_end_monitor.sv
`timescale 1ns/1ns
module metrology_front_end_monitor
	import metrology_pkg::*;
#(
	parameter int CPU_ADDR_W = 12
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [CPU_ADDR_W-1:0] cpuAddr,
	input wire logic cpuWrEn,
	input wire logic cpuRdEn,
	input wire logic [7:0] cpuRdData,
	input wire logic cpuRdValid,
	input wire logic computeBusyPulse,
	input wire logic [STATUS_W-1:0] engineStatus,
	input wire logic tempCompByProcessor,
	input wire logic [WORD_W-1:0] engineGainA,
	input wire logic [WORD_W-1:0] activeGainA
);
	// ***********************************
	// port timing checks
	// ***********************************
	default clocking mon_cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_read_answer: assert property (!$past(rst) |-> cpuRdValid == $past(cpuRdEn))
		else $error("read answer not one cycle after request");
	chk_rd_hold: assert property ($changed(cpuRdData) |-> cpuRdValid)
		else $error("read byte moved without a read");
	chk_busy_single: assert property (computeBusyPulse |=> !computeBusyPulse [*8])
		else $error("busy pulse too long or too close");
	chk_status_moves: assert property ($changed(engineStatus) |-> computeBusyPulse)
		else $error("status changed between passes");
	chk_status_top: assert property (cpuRdEn && cpuAddr[CPU_ADDR_W-1:2] == ADDR_STATUS
		&& cpuAddr[1:0] != 2'h3 |=> cpuRdData == 8'h00)
		else $error("status upper byte not zero");
	chk_status_low: assert property (cpuRdEn && cpuAddr == {ADDR_STATUS, 2'h3}
		|=> cpuRdData == {4'h0, $past(engineStatus)})
		else $error("status low byte differs from flags");
	chk_gain_engine: assert property (!$past(rst) && !tempCompByProcessor
		|-> activeGainA == $past(engineGainA))
		else $error("engine gain not passed through");
	chk_temp_cause: assert property ($changed(tempCompByProcessor) |-> $past(cpuWrEn, 2))
		else $error("compensation owner moved without a write");

	cover property (computeBusyPulse && engineStatus[0]);
	cover property ($rose(tempCompByProcessor));
	cover property (cpuRdValid && cpuRdData != 8'h00);
endmodule // metrology_front_end_monitor

bind metrology_front_end metrology_front_end_monitor #(.CPU_ADDR_W(CPU_ADDR_W)) u_mon (
	.sys_clk, .rst, .cpuAddr, .cpuWrEn, .cpuRdEn, .cpuRdData, .cpuRdValid,
	.computeBusyPulse, .engineStatus, .tempCompByProcessor, .engineGainA, .activeGainA
);

// >>> bench/cpu_port_model.sv
`timescale 1ns/1ns
module cpu_port_model (
	input wire logic sys_clk,
	input wire logic [7:0] cpuRdData,
	input wire logic cpuRdValid,
	output logic [11:0] cpuAddr,
	output logic cpuWrEn,
	output logic [7:0] cpuWrData,
	output logic cpuRdEn
);
	// ***********************************
	// byte cycles
	// ***********************************
	int idleGap = 0;

	initial begin
		cpuAddr = 12'h000;
		cpuWrEn = 1'b0;
		cpuWrData = 8'h00;
		cpuRdEn = 1'b0;
	end

	// released lines flip so a stale value never looks like a request
	task automatic byte_cycle(input logic [11:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge sys_clk);
		#1;
		cpuAddr = a;
		cpuWrEn = w;
		cpuRdEn = !w;
		cpuWrData = d;
		@(posedge sys_clk);
		#1;
		q = cpuRdValid ? cpuRdData : 8'hxx;
		cpuWrEn = 1'b0;
		cpuRdEn = 1'b0;
		cpuAddr = ~a;
		cpuWrData = ~d;
		repeat (idleGap) @(posedge sys_clk);
	endtask

	// most significant lane first
	task automatic wr_word(input logic [9:0] a, input logic [31:0] d);
		logic [7:0] q;
		for (int i = 0; i < 4; i++) begin
			byte_cycle({a, 2'(i)}, 1'b1, d[31-8*i -: 8], q);
		end
	endtask

	task automatic rd_word(input logic [9:0] a, output logic [31:0] d);
		for (int i = 0; i < 4; i++) begin
			byte_cycle({a, 2'(i)}, 1'b0, 8'h00, d[31-8*i -: 8]);
		end
	endtask
endmodule // cpu_port_model

// >>> bench/metrology_front_end_tb_top.sv
`timescale 1ns/1ns
module metrology_front_end_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic tickPin = 1'b0;
	logic [3:0] multiplexerDivider = 4'h7;
	logic [3:0] diffEn = 4'h0;
	logic [2:0] rmtEn = 3'h0;
	logic adcSampleValid = 1'b0;
	logic remoteSampleValid = 1'b0;
	logic [3:0] frameSlotInputSelect = 4'h0;
	logic [1:0] remotePair = 2'h0;
	logic [31:0] adcSample = 32'h0;
	logic [31:0] remoteSample = 32'h0;
	logic [31:0] realEnergySum = 32'h1234_5678;
	logic [31:0] reactiveEnergySum = 32'h0abc_def0;
	logic [31:0] engineGainA = 32'h0000_0111;
	logic [31:0] engineGainB = 32'h0000_0222;
	logic [31:0] engineGainC = 32'h0000_0333;
	logic [11:0] cpuAddr;
	logic [7:0] cpuWrData, cpuRdData;
	logic cpuWrEn, cpuRdEn, cpuRdValid, computeBusyPulse, tempCompByProcessor;
	logic [3:0] engineStatus;
	logic [31:0] activeGainA, activeGainB, activeGainC, pulseRateReal, pulseRateReactive;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	// {diff 67/45/23/01, remote 67/45/23, remote path, handle or pair, stored}
	logic [12:0] routeRows [14] = '{
		{4'h0, 3'h0, 1'b0, 4'h1, 1'b1}, {4'h1, 3'h0, 1'b0, 4'h1, 1'b0},
		{4'h1, 3'h0, 1'b0, 4'h0, 1'b1}, {4'h2, 3'h0, 1'b0, 4'h3, 1'b0},
		{4'h2, 3'h0, 1'b0, 4'h2, 1'b1}, {4'h0, 3'h1, 1'b0, 4'h2, 1'b0},
		{4'h2, 3'h1, 1'b1, 4'h0, 1'b1}, {4'h0, 3'h0, 1'b1, 4'h0, 1'b0},
		{4'h0, 3'h2, 1'b1, 4'h1, 1'b1}, {4'h8, 3'h4, 1'b1, 4'h2, 1'b1},
		{4'h8, 3'h0, 1'b0, 4'h7, 1'b0}, {4'h0, 3'h0, 1'b0, 4'ha, 1'b1},
		{4'hf, 3'h7, 1'b0, 4'h9, 1'b1}, {4'h0, 3'h4, 1'b0, 4'h6, 1'b0}};
	// {phase a, phase b, phase c, flags}, threshold 0x100, count 2
	logic [51:0] sagRows [7] = '{
		{16'h0050, 16'h0300, 16'h0300, 4'h8}, {16'h0300, 16'h0050, 16'h0300, 4'h8},
		{16'h0050, 16'h0050, 16'h0050, 4'ha}, {16'h0050, 16'h0100, 16'h0300, 4'hb},
		{16'h0101, 16'h0101, 16'h0050, 4'h8}, {16'hff00, 16'h0300, 16'h0050, 4'h4},
		{16'h0200, 16'h0300, 16'h0300, 4'h8}};

	metrology_front_end u_dut (
		.sys_clk, .rst, .tickPin, .multiplexerDivider,
		.pair01DifferentialEnable(diffEn[0]), .pair23DifferentialEnable(diffEn[1]),
		.pair45DifferentialEnable(diffEn[2]), .pair67DifferentialEnable(diffEn[3]),
		.pair23RemoteEnable(rmtEn[0]), .pair45RemoteEnable(rmtEn[1]),
		.pair67RemoteEnable(rmtEn[2]), .adcSampleValid, .frameSlotInputSelect, .adcSample,
		.remoteSampleValid, .remotePair, .remoteSample, .realEnergySum, .reactiveEnergySum,
		.engineGainA, .engineGainB, .engineGainC, .cpuAddr, .cpuWrEn, .cpuWrData, .cpuRdEn,
		.cpuRdData, .cpuRdValid, .computeBusyPulse, .engineStatus, .tempCompByProcessor,
		.activeGainA, .activeGainB, .activeGainC, .pulseRateReal, .pulseRateReactive);

	cpu_port_model u_cpu (.sys_clk, .cpuRdData, .cpuRdValid, .cpuAddr, .cpuWrEn,
		.cpuWrData, .cpuRdEn);

	// ***********************************
	// clock, fast reference tick, timeout
	// ***********************************
	always #25 sys_clk = ~sys_clk;

	// tick sped up to eight clocks so a pass fits in about a hundred cycles
	always begin
		repeat (4) @(posedge sys_clk);
		#1 tickPin = ~tickPin;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ***********************************
	// helpers
	// ***********************************
	task automatic tally_and_finish();
		if (failures == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic send(input logic rem, input logic [3:0] h, input logic [31:0] d);
		@(posedge sys_clk);
		#1;
		adcSampleValid = !rem;
		remoteSampleValid = rem;
		frameSlotInputSelect = h;
		remotePair = h[1:0];
		adcSample = d;
		remoteSample = d;
		@(posedge sys_clk);
		#1;
		adcSampleValid = 1'b0;
		remoteSampleValid = 1'b0;
		adcSample = ~d;
		remoteSample = ~d;
	endtask

	task automatic wait_pass(output int n);
		n = 0;
		@(posedge sys_clk);
		#1;
		while (computeBusyPulse !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 400) failures++;
	endtask

	// ***********************************
	// main sequence
	// ***********************************
	initial begin
		logic [31:0] w, prior;
		logic [7:0] b;
		logic [9:0] loc;
		logic [3:0] h;
		logic rem, st;
		int n;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		u_cpu.rd_word(10'h020, w);
		check(w, 32'h0030da20);
		u_cpu.rd_word(10'h080, w);
		check(w, 32'h0);
		u_cpu.byte_cycle({10'h020, 2'h3}, 1'b0, 8'h00, b);
		check({24'h0, b}, 32'h20);
		u_cpu.rd_word(10'h3ff, w);
		check(w, 32'h0);
		foreach (routeRows[i]) begin
			{diffEn, rmtEn, rem, h, st} = routeRows[i];
			loc = rem ? 10'(2 * h + 2) : 10'(h);
			u_cpu.rd_word(loc, prior);
			send(rem, h, 32'h5a5a_0000 + i);
			u_cpu.rd_word(loc, w);
			check(w, st ? 32'h5a5a_0000 + i : prior);
		end
		diffEn = 4'h0;
		rmtEn = 3'h0;
		wait_pass(n);
		wait_pass(n);
		check(n + 1, 15 * 8);
		multiplexerDivider = 4'h6;
		repeat (2) wait_pass(n);
		wait_pass(n);
		check(n + 1, 13 * 8);
		repeat (2) @(posedge sys_clk);
		#1;
		check(pulseRateReal, realEnergySum);
		check(pulseRateReactive, reactiveEnergySum);
		u_cpu.rd_word(10'h084, w);
		check(w, realEnergySum);
		u_cpu.rd_word(10'h088, w);
		check(w, reactiveEnergySum);
		// a high phase a first, so the zero left at reset never counts as low
		send(1'b0, 4'h8, 32'h300);
		u_cpu.wr_word(10'h024, 32'h100);
		u_cpu.wr_word(10'h020, 32'h0030_0220);
		wait_pass(n);
		foreach (sagRows[i]) begin
			for (int p = 0; p < 3; p++) begin
				w = {{16{sagRows[i][51-16*p]}}, sagRows[i][51-16*p -: 16]};
				send(1'b0, 4'(8 + p), w);
			end
			wait_pass(n);
			check({28'h0, engineStatus}, {28'h0, sagRows[i][3:0]});
			u_cpu.rd_word(10'h080, w);
			check(w, {28'h0, sagRows[i][3:0]});
		end
		u_cpu.idleGap = 3;
		u_cpu.wr_word(10'h080, 32'hffff_ffff);
		u_cpu.rd_word(10'h080, w);
		check(w, 32'h8);
		u_cpu.wr_word(10'h00a, 32'h1111_1111);
		u_cpu.rd_word(10'h00a, w);
		check(w, 32'h300);
		u_cpu.idleGap = 0;
		u_cpu.wr_word(10'h044, 32'h777);
		u_cpu.wr_word(10'h048, 32'h555);
		u_cpu.wr_word(10'h020, 32'h0030_0230);
		@(posedge sys_clk);
		#1;
		check(pulseRateReal, 32'h777);
		check(pulseRateReactive, 32'h555);
		realEnergySum = 32'h0;
		wait_pass(n);
		repeat (2) @(posedge sys_clk);
		#1;
		check(pulseRateReal, 32'h777);
		u_cpu.wr_word(10'h040, 32'haaa);
		u_cpu.wr_word(10'h020, 32'h0070_0230);
		@(posedge sys_clk);
		#1;
		check({31'h0, tempCompByProcessor}, 32'h1);
		check(activeGainA, 32'haaa);
		check(activeGainB, 32'h0);
		check(activeGainC, 32'h0);
		u_cpu.wr_word(10'h020, 32'h0030_0230);
		@(posedge sys_clk);
		#1;
		check(activeGainA, engineGainA);
		check(activeGainB, engineGainB);
		check(activeGainC, engineGainC);
		// phase b negative, a and c positive: only a phase b source clears the square bit
		wait_pass(n);
		send(1'b0, 4'h9, 32'hffff_ff00);
		u_cpu.byte_cycle({10'h020, 2'h3}, 1'b1, 8'h60, b);
		wait_pass(n);
		check({28'h0, engineStatus}, 32'h0);
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		u_cpu.rd_word(10'h020, w);
		check(w, 32'h0030da20);
		check({28'h0, engineStatus}, 32'h0);
		tally_and_finish();
	end
endmodule // metrology_front_end_tb_top
